// File: src/twm_monitor.sv
// Top of the temperature window monitor: sequencer, comparator and alarm
`timescale 1ns/1ps
module twm_monitor #(
    parameter longint FIRST_CYC = twm_pkg::FIRST_TYP_CYC,   // Start-up to first conversion request
    parameter longint PERIOD_CYC = twm_pkg::PERIOD_MAX_CYC - 1  // Reload count; spacing is one cycle more
) (
    input wire logic clk_i,
    input wire logic rst_i,                                  // Power-on reset
    input wire logic hysteresis_select_low_bit,              // Static strap
    input wire logic hysteresis_select_high_bit,             // Static strap
    input wire logic force_alarm_high,                       // Test override, active high
    input wire twm_pkg::twm_temp_type temp_i,                // Conversion result
    input wire logic temp_valid_i,                           // Result strobe
    output logic conv_start_o,                               // Request to front end, pulse
    output logic alarm_o                                     // Out-of-window alarm
);
    import twm_pkg::*;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // Counts must fit the timebase; zero is rejected, though it would tick like one
    if (FIRST_CYC < 1 || PERIOD_CYC < 1 || FIRST_CYC >= (64'h1 << TIMER_W)
            || PERIOD_CYC >= (64'h1 << TIMER_W)) begin : g_bad_timing
        $error("twm_monitor: timing parameter out of range");
    end

    twm_state_type state_r;                 // Sequencer state
    logic tick;                             // Timebase expiry
    logic restart;                          // Timebase reload
    logic [TIMER_W-1:0] reload;             // Reload value
    logic alarm_state_r;                    // Comparator alarm latch
    twm_temp_type hyst;                     // Decoded hysteresis
    logic outside;                          // Result beyond trip window
    logic inside_hyst;                      // Result within shrunk window
    logic first_done_r;                     // A result was accepted

    // ----------------------------------------
    // Hysteresis decode
    // ----------------------------------------
    // Straps are read continuously; a single mode, no stored config
    always_comb begin
        unique case ({hysteresis_select_high_bit, hysteresis_select_low_bit})
            2'b00: hyst = HYST_1;
            2'b01: hyst = HYST_2;
            2'b10: hyst = HYST_5;
            2'b11: hyst = HYST_10;
        endcase
    end

    // Window compare against factory thresholds
    assign outside = (temp_i < TRIP_LOW) || (temp_i > TRIP_HIGH);
    // Release needs margin from both edges
    assign inside_hyst = (temp_i > TRIP_LOW + hyst) && (temp_i < TRIP_HIGH - hyst);

    // ----------------------------------------
    // Conversion timebase
    // ----------------------------------------
    // Start-up delay on first tick, then fixed period
    assign restart = (state_r == TWM_ST_STARTUP) || tick;
    assign reload = (state_r == TWM_ST_STARTUP) ? TIMER_W'(FIRST_CYC) : TIMER_W'(PERIOD_CYC);

    twm_timebase #(
        .WIDTH(TIMER_W)
    ) u_timebase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .count_i(reload),
        .tick_o(tick)
    );

    // Every tick requests a conversion
    assign conv_start_o = tick;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Reset stands in for supply reaching its minimum level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= TWM_ST_STARTUP;
        end else begin
            unique case (state_r)
                TWM_ST_STARTUP: state_r <= TWM_ST_WAIT_FIRST;
                TWM_ST_WAIT_FIRST: begin
                    if (tick) begin
                        state_r <= TWM_ST_RUN;
                    end
                end
                TWM_ST_RUN: state_r <= TWM_ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Alarm latch
    // ----------------------------------------
    // Set at power-up; changes only on a result strobe, so it moves at most
    // once per accepted result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_state_r <= 1'b1;
            first_done_r <= 1'b0;
        end else if (temp_valid_i) begin
            first_done_r <= 1'b1;
            if (outside) begin
                alarm_state_r <= 1'b1;
            end else if (inside_hyst) begin
                alarm_state_r <= 1'b0;
            end
        end
    end

    // Force input overrides combinationally, low has no effect
    assign alarm_o = alarm_state_r | force_alarm_high;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_force_high: assert property (@(posedge clk_i) disable iff (rst_i)
        force_alarm_high |-> alarm_o)
        else $error("alarm low while forced");
    a_leave_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        temp_valid_i && outside |=> alarm_o)
        else $error("alarm not set on window exit");
    a_release_hyst: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(alarm_state_r) |-> $past(temp_valid_i) && $past(inside_hyst))
        else $error("alarm released outside hysteresis window");
    a_hold_nostrobe: assert property (@(posedge clk_i) disable iff (rst_i)
        !temp_valid_i |=> $stable(alarm_state_r))
        else $error("alarm changed without strobe");
    a_powerup_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !first_done_r |-> alarm_state_r)
        else $error("alarm low before first result");
    a_hyst_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        hysteresis_select_high_bit && hysteresis_select_low_bit |-> hyst == HYST_10)
        else $error("hysteresis decode wrong");
    a_first_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == TWM_ST_WAIT_FIRST && tick |=> state_r == TWM_ST_RUN)
        else $error("first conversion did not start run");
    a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        tick |=> !tick)
        else $error("conversion requests back to back");
    a_no_effect_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !force_alarm_high |-> alarm_o == alarm_state_r)
        else $error("idle force input changed alarm");
    a_reset_high: assert property (@(posedge clk_i)
        rst_i |=> alarm_o)
        else $error("alarm low after reset edge");
    a_hyst_two: assert property (@(posedge clk_i) disable iff (rst_i)
        !hysteresis_select_high_bit && hysteresis_select_low_bit |-> hyst == HYST_2)
        else $error("hysteresis decode wrong for code one");

    c_first_release: cover property (@(posedge clk_i) disable iff (rst_i) $fell(alarm_o));
    c_forced: cover property (@(posedge clk_i) disable iff (rst_i) force_alarm_high && !alarm_state_r);
    c_trip: cover property (@(posedge clk_i) disable iff (rst_i) $rose(alarm_state_r));
    c_run: cover property (@(posedge clk_i) disable iff (rst_i) state_r == TWM_ST_RUN && tick);
endmodule

// File: src/twm_pkg.sv
// Package with constants and types of the temperature window monitor
// Operation
// - Select pins pick 1, 2, 5, 10 degrees
// - Fixed lower and upper trip thresholds
// - Alarm rises when result leaves window
// - Alarm falls only inside hysteresis-shrunk window
// - Force input drives alarm high immediately
// - Low force input has no effect
// - Alarm high at power-up until first conversion
// - First conversion completes within 20-35 ms
// - Later results every 0.985 to 1 s
// - Single mode, static configuration only
package twm_pkg;
    // ----------------------------------------
    // Temperature format
    // ----------------------------------------
    localparam int TEMP_W = 12;                        // Signed whole degrees
    typedef logic signed [TEMP_W-1:0] twm_temp_type;
    // Factory trip thresholds in degrees
    localparam twm_temp_type TRIP_LOW = 12'sh000;      // 0 degrees
    localparam twm_temp_type TRIP_HIGH = 12'sh03c;     // 60 degrees
    // Hysteresis values in degrees
    localparam twm_temp_type HYST_1 = 12'sh001;
    localparam twm_temp_type HYST_2 = 12'sh002;
    localparam twm_temp_type HYST_5 = 12'sh005;
    localparam twm_temp_type HYST_10 = 12'sh00a;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam longint FIRST_CONV_MIN_US = 20000;      // 20 ms
    localparam longint FIRST_CONV_MAX_US = 35000;      // 35 ms
    localparam longint FIRST_CONV_TYP_US = 26000;      // 26 ms
    localparam longint PERIOD_MIN_US = 985000;         // 0.985 s
    localparam longint PERIOD_MAX_US = 1000000;        // 1 s
    // Cycle counts: least times round up, longest round down
    localparam longint FIRST_MIN_CYC = (FIRST_CONV_MIN_US * CLK_HZ + 999999) / 1000000;
    localparam longint FIRST_MAX_CYC = (FIRST_CONV_MAX_US * CLK_HZ) / 1000000;
    localparam longint FIRST_TYP_CYC = (FIRST_CONV_TYP_US * CLK_HZ) / 1000000;
    localparam longint PERIOD_MIN_CYC = (PERIOD_MIN_US * CLK_HZ + 999999) / 1000000;
    localparam longint PERIOD_MAX_CYC = (PERIOD_MAX_US * CLK_HZ) / 1000000;
    localparam int TIMER_W = 32;
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        TWM_ST_STARTUP,
        TWM_ST_WAIT_FIRST,
        TWM_ST_RUN
    } twm_state_type;
endpackage

// File: src/twm_timebase.sv
// Conversion timebase: one-cycle request pulse after a programmable count
`timescale 1ns/1ps
module twm_timebase #(
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,               // Reload and start counting
    input wire logic [WIDTH-1:0] count_i,     // Cycles until the tick
    output logic tick_o                       // One-cycle pulse at terminal count
);
    logic [WIDTH-1:0] cnt_r;                  // Remaining cycles
    logic run_r;                              // Counting in progress

    // The terminal compare needs at least two bits to tell one from zero
    if (WIDTH < 2) begin : g_bad_width
        $error("twm_timebase: counter width too small");
    end

    // Count down, pulse on reaching one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            cnt_r <= count_i;
            run_r <= 1'b1;
            tick_o <= 1'b0;
        end else if (run_r && cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            run_r <= 1'b0;
            tick_o <= 1'b1;
        end else begin
            if (run_r) begin
                cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
            end
            tick_o <= 1'b0;
        end
    end
endmodule

// File: testbench/twm_front_model.sv
// Front-end model that answers conversion requests with one result strobe
`timescale 1ns/1ps
module twm_front_model (
    input wire logic clk_i,
    input wire logic conv_start_i,
    input wire logic kick_i,
    input wire twm_pkg::twm_temp_type value_i,
    output twm_pkg::twm_temp_type temp_o,
    output logic temp_valid_o
);
    import twm_pkg::*;
    // ----------------------------------------
    // Request capture and answer
    // ----------------------------------------
    logic go_r = 1'b0; // Request seen, answer at next falling edge
    initial begin
        temp_o = 12'sh000;
        temp_valid_o = 1'b0;
    end
    // Requests come from the monitor or from the bench kick
    always @(posedge clk_i) begin
        go_r <= conv_start_i | kick_i;
    end
    // Off strobe the bus toggles, so a stale value never reads as a result
    always @(negedge clk_i) begin
        temp_valid_o <= go_r;
        temp_o <= go_r ? value_i : ~temp_o;
    end
endmodule

// File: testbench/temperature_window_monitor_bench.sv
// Self-checking bench for the temperature window monitor
`timescale 1ns/1ps
module temperature_window_monitor_bench;
    import twm_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sel_lo = 1'b0; // Straps stay static within each configuration
    logic sel_hi = 1'b0;
    logic force_hi = 1'b0;
    logic kick = 1'b0;
    twm_temp_type set_temp = 12'sh01e; // Temperature the model reports
    twm_temp_type temp;
    logic temp_valid;
    logic conv_start;
    logic alarm; // High reads as out of window
    int fail_count = 0;
    int compares = 0;
    int n;
    always #20 clk_i = ~clk_i;
    // Short counts keep the run brief
    twm_monitor #(.FIRST_CYC(20), .PERIOD_CYC(50)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .hysteresis_select_low_bit(sel_lo), .hysteresis_select_high_bit(sel_hi),
        .force_alarm_high(force_hi), .temp_i(temp), .temp_valid_i(temp_valid),
        .conv_start_o(conv_start), .alarm_o(alarm));
    twm_front_model fe (.clk_i(clk_i), .conv_start_i(conv_start), .kick_i(kick),
        .value_i(set_temp), .temp_o(temp), .temp_valid_o(temp_valid));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    // Bounded wait for the next conversion request
    task automatic wait_start(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_i);
            cnt++;
            if (cnt > 200) begin
                chk(1'b0, 1'b1, "no conversion request");
                end_sim();
            end
        end while (conv_start !== 1'b1);
    endtask
    // One result through the model, alarm checked after it lands
    task automatic conv(input int t, input logic exp, input string what);
        set_temp = t[TEMP_W-1:0];
        kick = 1'b1;
        @(negedge clk_i);
        kick = 1'b0;
        @(negedge clk_i);
        chk(alarm, exp, what);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic startup;
        wait_start(n);
        chk(n >= 20 && n <= 24, 1'b1, "first request timing");
        chk(alarm, 1'b1, "alarm before first result");
        repeat (2) @(negedge clk_i);
        chk(alarm, 1'b0, "first result in window");
    endtask
    task automatic period;
        wait_start(n);
        wait_start(n);
        chk(n == 51, 1'b1, "result period");
    endtask
    // Every strap code, both edges, band and release around each
    task automatic hyst_sweep;
        int h [4] = '{1, 2, 5, 10};
        for (int i = 0; i < 4; i++) begin
            {sel_hi, sel_lo} = i[1:0];
            conv(60, 1'b0, "upper threshold itself");
            conv(61, 1'b1, "above upper");
            conv(60 - h[i], 1'b1, "upper band holds");
            conv(59 - h[i], 1'b0, "upper release");
            conv(0, 1'b0, "lower threshold itself");
            conv(-1, 1'b1, "below lower");
            conv(h[i], 1'b1, "lower band holds");
            conv(h[i] + 1, 1'b0, "lower release");
        end
    endtask
    task automatic force_test;
        force_hi = 1'b1;
        #1 chk(alarm, 1'b1, "force acts at once");
        @(negedge clk_i);
        conv(30, 1'b1, "force inside window");
        force_hi = 1'b0;
        #1 chk(alarm, 1'b0, "force released");
        @(negedge clk_i);
        conv(30, 1'b0, "low force no effect");
    endtask
    // Mid-run reset: a first result in the band must keep the alarm high
    task automatic reset_band;
        {sel_hi, sel_lo} = 2'b11;
        set_temp = 12'sh037; // 55 degrees: inside the window, short of the 50 release point
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(alarm, 1'b1, "alarm high in mid-run reset");
        chk(conv_start, 1'b0, "no request in mid-run reset");
        rst_i = 1'b0;
        wait_start(n);
        chk(n >= 20 && n <= 24, 1'b1, "first request after mid-run reset");
        repeat (2) @(negedge clk_i);
        chk(alarm, 1'b1, "first result in band keeps alarm");
        conv(49, 1'b0, "release below upper minus ten");
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge clk_i);
        chk(alarm, 1'b1, "alarm in reset");
        chk(conv_start, 1'b0, "no request in reset");
        rst_i = 1'b0;
        startup();
        period();
        hyst_sweep();
        force_test();
        reset_band();
        end_sim();
    end
endmodule
